// ==== verilog/qei_cfg.svh ====
`ifndef QEI_CFG_SVH
`define QEI_CFG_SVH

`define OFS_CONTROL      5'h00
`define OFS_STATUS       5'h01
`define OFS_POSITION     5'h02
`define OFS_MAXPOS       5'h03
`define OFS_RELOAD       5'h04
`define OFS_TIMER        5'h05
`define OFS_VEL_ACC      5'h06
`define OFS_SPEED        5'h07
`define OFS_INT_MASK     5'h08
`define OFS_INT_RAW      5'h09
`define OFS_INT_CLEAR    5'h0a

`define CTL_ENABLE_BIT   0
`define CTL_SWAP_BIT     1
`define CTL_SIGNAL_MODE_SELECT_BIT  2
`define CTL_CAPTURE_EDGES_SELECT_BIT  3
`define CTL_RESET_MODE_SELECT_BIT  4
`define CTL_VELEN_BIT    5
`define CTL_VELOCITY_PREDIVIDE_LSB   6
`define CTL_VELOCITY_PREDIVIDE_MSB   8
`define CTL_WIDTH        9
`define CTL_RESET        9'h000

`define EV_PHASE_ERR     0
`define EV_DIR_CHANGE    1
`define EV_INDEX         2
`define EV_TIMER         3
`define EV_COUNT         4

`define WORD_ZERO        32'h0000_0000
`define WORD_ONE         32'h0000_0001
`define PREDIV_ZERO      7'h00
`define PREDIV_ONE       7'h01
`define PREDIV_FULL      8'h7f
`define PREDIV_TOP       3'h7
`define EV_ZERO          4'h0

`endif

// ==== verilog/qei_pkg.sv ====
package qei_pkg;

	typedef struct packed
	{
		logic [2:0] velocity_predivide;
		logic       vel_enable;
		logic       reset_mode_select;
		logic       capture_edges_select;
		logic       signal_mode_select;
		logic       swap;
		logic       enable;
	} encoder_control_s;

	typedef struct packed
	{
		logic step;
		logic up;
		logic phase_err;
		logic dir_flip;
		logic index;
	} edge_event_s;

	typedef struct packed
	{
		logic [4:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_s;

endpackage : qei_pkg

// ==== verilog/edge_decoder.sv ====
`timescale 1ns/1ns
`include "qei_cfg.svh"

module edge_decoder
(
	input  wire logic                      i_mclk,
	input  wire logic                      i_sys_rst,
	input  wire logic                      i_phase_a_input,
	input  wire logic                      i_phase_b_input,
	input  wire logic                      i_index_input,
	input  wire qei_pkg::encoder_control_s i_ctl,
	output qei_pkg::edge_event_s           o_ev,
	output logic                           o_direction
);
	logic [2:0] meta_r;
	logic [2:0] sync_r;
	logic [2:0] prev_r;
	logic       dir_r;
	logic       last_ch_r;
	logic       last_ch_valid_r;
	logic       pa;
	logic       pb;
	logic       pa_old;
	logic       pb_old;
	logic       ea;
	logic       eb;
	logic       up;

	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			meta_r <= 3'h0;
			sync_r <= 3'h0;
			prev_r <= 3'h0;
		end
		else
		begin
			meta_r <= {i_index_input, i_phase_b_input, i_phase_a_input}; // [RULE19]
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	// Swap before any decoding
	assign pa     = i_ctl.swap ? sync_r[1] : sync_r[0]; // [RULE2]
	assign pb     = i_ctl.swap ? sync_r[0] : sync_r[1];
	assign pa_old = i_ctl.swap ? prev_r[1] : prev_r[0];
	assign pb_old = i_ctl.swap ? prev_r[0] : prev_r[1];
	assign ea     = pa ^ pa_old; // [RULE19]
	assign eb     = pb ^ pb_old;
	// A lead B: after an A edge, A differs from B
	assign up     = ea ? (pa != pb) : (pa == pb); // [RULE6]

	always_comb
	begin
		o_ev       = '0;
		o_ev.index = sync_r[2] & ~prev_r[2];
		if (i_ctl.signal_mode_select) // [RULE3]
		begin
			o_ev.step = pa & ~pa_old; // [RULE4]
			o_ev.up   = ~pb;
		end
		else if (ea & eb)
		begin
			o_ev.phase_err = 1'b1; // [RULE20]
		end
		else
		begin
			o_ev.step     = ea | (eb & i_ctl.capture_edges_select); // [RULE5] [RULE15]
			o_ev.up       = up;
			o_ev.dir_flip = (ea | eb) & last_ch_valid_r & (last_ch_r == eb) & (up != dir_r); // [RULE7]
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			dir_r           <= 1'b1;
			last_ch_r       <= 1'b0;
			last_ch_valid_r <= 1'b0;
		end
		else if (!i_ctl.signal_mode_select && (ea ^ eb))
		begin
			dir_r           <= up;
			last_ch_r       <= eb;
			last_ch_valid_r <= 1'b1;
		end
		else if (i_ctl.signal_mode_select && o_ev.step)
		begin
			dir_r <= ~pb;
		end
	end

	assign o_direction = dir_r;

endmodule : edge_decoder

// ==== verilog/quadrature_encoder_interface.sv ====
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ns
`include "qei_cfg.svh"

// How it works
// [RULE1] Position and velocity enable apart; velocity runs only with position enabled.
// [RULE2] Swap control exchanges the phase inputs before decoding, reversing direction.
// [RULE3] Signal mode picks quadrature phases or step clock plus direction level.
// [RULE4] Clock/direction: each step advances position by one, direction level picks sign.
// [RULE5] Capture-edges picks first-phase edges only or edges of both phases.
// [RULE6] First phase leading counts up; second phase leading counts down.
// [RULE7] Edge pair on one phase with none on the other marks direction change.
// [RULE8] Reset-mode bit picks index reset or reset at the programmed maximum.
// [RULE9] Index mode: index clears position; down from zero loads the maximum.
// [RULE10] Maximum mode: position stays within zero to maximum; index ignored.
// [RULE11] Software programs maximum as edges per revolution minus one.
// [RULE12] Velocity counts edges per timer period with the same edge selection.
// [RULE13] Period end copies count into speed, then clears the accumulator.
// [RULE14] Timer counts down from reload, raises expiry at zero, reloads and continues.
// [RULE15] One encoder pulse gives two edges, or four with both-phase capture.
// [RULE16] Events: phase error, direction change, index, timer; mask, raw, masked, clear.
// [RULE17] Software writes control, then maximum, then sets the enable bit.
// [RULE18] Predivider divides counted edges by one to 128 before accumulation.
// [RULE19] Phase and index inputs are synchronised and edge-detected first.
// [RULE20] Both phases changing in one cycle flags phase error, no position change.
// [RULE21] While disabled, counters and timer hold and no events are raised.

module quadrature_encoder_interface
(
	input  wire logic        i_mclk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_phase_a_input,
	input  wire logic        i_phase_b_input,
	input  wire logic        i_index_input,
	input  wire logic [4:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	output logic             o_direction,
	output logic             o_event_pending
);
	qei_pkg::encoder_control_s ctl_r;
	qei_pkg::edge_event_s      ev;
	qei_pkg::reg_req_s         req;
	logic [31:0]               position_value_r;
	logic [31:0]               max_position_value_r;
	logic [31:0]               timer_reload_value_r;
	logic [31:0]               timer_r;
	logic [31:0]               velocity_accumulator_r;
	logic [31:0]               speed_result_r;
	logic [6:0]                prediv_r;
	logic [6:0]                prediv_mask;
	logic [3:0]                mask_r;
	logic [3:0]                raw_r;
	logic [3:0]                ev_now;
	logic [3:0]                clr;
	logic                      run;
	logic                      vel_run;
	logic                      expire;
	logic                      vel_edge;
	logic                      pos_step;
	logic [31:0]               rdata_nxt;
	logic                      wr_ctl;
	logic                      wr_max;
	logic                      wr_reload;
	logic                      wr_mask;
	logic                      wr_pos;
	logic                      wr_clear;

	assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

	// One decode per register so each block below sees a single qualifier
	assign wr_ctl    = req.wr & (req.addr == `OFS_CONTROL);
	assign wr_max    = req.wr & (req.addr == `OFS_MAXPOS);
	assign wr_reload = req.wr & (req.addr == `OFS_RELOAD);
	assign wr_mask   = req.wr & (req.addr == `OFS_INT_MASK);
	assign wr_pos    = req.wr & (req.addr == `OFS_POSITION);
	assign wr_clear  = req.wr & (req.addr == `OFS_INT_CLEAR);

	edge_decoder i_edge_decoder
	(
		.i_mclk          (i_mclk),
		.i_sys_rst       (i_sys_rst),
		.i_phase_a_input (i_phase_a_input),
		.i_phase_b_input (i_phase_b_input),
		.i_index_input   (i_index_input),
		.i_ctl           (ctl_r),
		.o_ev            (ev),
		.o_direction     (o_direction)
	);

	assign run      = ctl_r.enable; // [RULE21]
	assign vel_run  = ctl_r.enable & ctl_r.vel_enable; // [RULE1]
	assign pos_step = run & ev.step;
	assign expire   = vel_run & (timer_r == `WORD_ZERO); // [RULE14]

	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			ctl_r <= `CTL_RESET;
		end
		else if (wr_ctl)
		begin
			ctl_r <= req.wdata[`CTL_WIDTH-1:0];
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			max_position_value_r <= `WORD_ZERO;
		end
		else if (wr_max)
		begin
			max_position_value_r <= req.wdata; // [RULE10]
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			timer_reload_value_r <= `WORD_ZERO;
		end
		else if (wr_reload)
		begin
			timer_reload_value_r <= req.wdata; // [RULE14]
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			mask_r <= `EV_ZERO;
		end
		else if (wr_mask)
		begin
			mask_r <= req.wdata[`EV_COUNT-1:0]; // [RULE16]
		end
	end

	// Position integrator
	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			position_value_r <= `WORD_ZERO;
		end
		else if (wr_pos)
		begin
			// A software write wins over a step in the same cycle
			position_value_r <= req.wdata;
		end
		else if (run)
		begin
			if (!ctl_r.reset_mode_select && ev.index) // [RULE8] [RULE9]
				position_value_r <= `WORD_ZERO;
			else if (pos_step && ev.up)
			begin
				if (position_value_r >= max_position_value_r) // [RULE10]
					position_value_r <= `WORD_ZERO;
				else
					position_value_r <= position_value_r + `WORD_ONE; // [RULE4] [RULE6]
			end
			else if (pos_step)
			begin
				if (position_value_r == `WORD_ZERO) // [RULE9] [RULE11]
					position_value_r <= max_position_value_r;
				else
					position_value_r <= position_value_r - `WORD_ONE; // [RULE6]
			end
		end
	end

	// Velocity timer; the zero cycle reloads, so a period is reload plus one
	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			timer_r <= `WORD_ZERO;
		end
		else if (expire)
		begin
			timer_r <= timer_reload_value_r; // [RULE14]
		end
		else if (vel_run)
		begin
			timer_r <= timer_r - `WORD_ONE;
		end
	end

	// Predivider: power-of-two mask on a free edge counter
	assign prediv_mask = 7'((`PREDIV_FULL >> (`PREDIV_TOP - ctl_r.velocity_predivide))); // [RULE18]
	assign vel_edge    = vel_run & ev.step & ((prediv_r & prediv_mask) == prediv_mask); // [RULE12]

	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			prediv_r <= `PREDIV_ZERO;
		end
		else if (vel_run && ev.step)
		begin
			prediv_r <= prediv_r + `PREDIV_ONE;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			velocity_accumulator_r <= `WORD_ZERO;
		end
		else if (expire)
		begin
			velocity_accumulator_r <= `WORD_ZERO; // [RULE13]
		end
		else if (vel_edge)
		begin
			velocity_accumulator_r <= velocity_accumulator_r + `WORD_ONE; // [RULE12]
		end
	end

	// An edge on the expiry cycle still lands in the closing period
	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			speed_result_r <= `WORD_ZERO;
		end
		else if (expire)
		begin
			speed_result_r <= velocity_accumulator_r + {31'h0, vel_edge}; // [RULE13]
		end
	end

	// Events; set wins over write-one clear
	assign ev_now[`EV_PHASE_ERR]  = run & ev.phase_err; // [RULE16] [RULE20]
	assign ev_now[`EV_DIR_CHANGE] = run & ev.dir_flip;
	assign ev_now[`EV_INDEX]      = run & ev.index;
	assign ev_now[`EV_TIMER]      = expire;
	assign clr = wr_clear ? req.wdata[`EV_COUNT-1:0] : `EV_ZERO;

	generate
		for (genvar g = 0; g < `EV_COUNT; g++)
		begin : g_event
			always_ff @(posedge i_mclk)
			begin
				if (i_sys_rst)
				begin
					raw_r[g] <= 1'b0;
				end
				else if (ev_now[g])
				begin
					raw_r[g] <= 1'b1; // [RULE16]
				end
				else if (clr[g])
				begin
					raw_r[g] <= 1'b0;
				end
			end
		end
	endgenerate

	assign o_event_pending = |(raw_r & mask_r); // [RULE16]

	always_comb
	begin
		unique case (req.addr)
			`OFS_CONTROL:   rdata_nxt = {23'h0, ctl_r};
			`OFS_STATUS:    rdata_nxt = {30'h0, o_direction, ~ev.up};
			`OFS_POSITION:  rdata_nxt = position_value_r;
			`OFS_MAXPOS:    rdata_nxt = max_position_value_r;
			`OFS_RELOAD:    rdata_nxt = timer_reload_value_r;
			`OFS_TIMER:     rdata_nxt = timer_r;
			`OFS_VEL_ACC:   rdata_nxt = velocity_accumulator_r;
			`OFS_SPEED:     rdata_nxt = speed_result_r;
			`OFS_INT_MASK:  rdata_nxt = {28'h0, mask_r};
			`OFS_INT_RAW:   rdata_nxt = {28'h0, raw_r};
			`OFS_INT_CLEAR: rdata_nxt = {28'h0, raw_r & mask_r};
			default:        rdata_nxt = `WORD_ZERO;
		endcase
	end

	// Read data valid only the cycle after the strobe
	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			o_rdata <= `WORD_ZERO;
		end
		else if (req.rd)
		begin
			o_rdata <= rdata_nxt;
		end
		else
		begin
			o_rdata <= `WORD_ZERO;
		end
	end

endmodule : quadrature_encoder_interface

// ==== tb/quadrature_encoder_interface_monitor.sv ====
`timescale 1ns/1ns
`include "qei_cfg.svh"

module quadrature_encoder_interface_monitor
(
	input wire logic        i_mclk,
	input wire logic        i_sys_rst,
	input wire logic        i_phase_a_input,
	input wire logic        i_phase_b_input,
	input wire logic        i_index_input,
	input wire logic [4:0]  i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic        o_direction,
	input wire logic        o_event_pending
);
	logic [3:0] mask_r;

	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);

	always_ff @(posedge i_mclk)
		if (i_sys_rst)
			mask_r <= 4'h0;
		else if (i_wr && i_addr == `OFS_INT_MASK)
			mask_r <= i_wdata[3:0];

	a_reset_values: assert property ($fell(i_sys_rst) |-> o_direction && !o_event_pending && o_rdata == 32'h0)
		else $error("reset values");
	a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("rdata not idle");
	a_unmapped_zero: assert property (i_rd && i_addr > `OFS_INT_CLEAR |=> o_rdata == 32'h0)
		else $error("unmapped read");
	a_status_dir: assert property (i_rd && i_addr == `OFS_STATUS |=> o_rdata[1] == $past(o_direction))
		else $error("status direction");
	// Writes excluded: a mode change may legally move the direction
	a_dir_hold: assert property ((!i_wr && $stable({i_phase_a_input, i_phase_b_input}))[*6]
		|=> $stable(o_direction)) else $error("direction moved");
	a_mask_gate: assert property (mask_r == 4'h0 |-> !o_event_pending)
		else $error("pending while masked");
	a_mask_readback: assert property (i_wr && i_addr == `OFS_INT_MASK ##2 i_rd && i_addr == `OFS_INT_MASK
		|=> o_rdata == ($past(i_wdata, 3) & 32'hf)) else $error("mask readback");
	a_max_readback: assert property (i_wr && i_addr == `OFS_MAXPOS ##2 i_rd && i_addr == `OFS_MAXPOS
		|=> o_rdata == $past(i_wdata, 3)) else $error("max readback");
endmodule : quadrature_encoder_interface_monitor

bind quadrature_encoder_interface quadrature_encoder_interface_monitor i_quadrature_encoder_interface_monitor
(
	.i_mclk, .i_sys_rst, .i_phase_a_input, .i_phase_b_input, .i_index_input, .i_addr,
	.i_wdata, .i_wr, .i_rd, .o_rdata, .o_direction, .o_event_pending
);

// ==== tb/encoder_model.sv ====
`timescale 1ns/1ns

module encoder_model
(
	input  wire logic i_mclk,
	output logic      o_phase_a,
	output logic      o_phase_b,
	output logic      o_index
);
	// Each level outlasts the two-stage synchroniser
	localparam int QTR = 6;

	initial
	begin
		o_phase_a = 1'b0;
		o_phase_b = 1'b0;
		o_index   = 1'b0;
	end

	// Levels change on a rising edge, like every other bench input
	task automatic hold(input logic a, input logic b, input logic x);
		@(posedge i_mclk);
		o_phase_a <= a;
		o_phase_b <= b;
		o_index   <= x;
		repeat (QTR - 1) @(posedge i_mclk);
	endtask : hold

	task automatic quad(input logic fwd, input int n);
		repeat (n)
		begin
			hold(fwd, !fwd, 1'b0);
			hold(1'b1, 1'b1, 1'b0);
			hold(!fwd, fwd, 1'b0);
			hold(1'b0, 1'b0, 1'b0);
		end
	endtask : quad

	task automatic steps(input logic down, input int n);
		hold(1'b0, down, 1'b0);
		repeat (n)
		begin
			hold(1'b1, down, 1'b0);
			hold(1'b0, down, 1'b0);
		end
		hold(1'b0, 1'b0, 1'b0);
	endtask : steps

	// One level then idle; faults only when a test asks
	task automatic blip(input logic a, input logic b, input logic x);
		hold(a, b, x);
		hold(1'b0, 1'b0, 1'b0);
	endtask : blip
endmodule : encoder_model

// ==== tb/tb_quadrature_encoder_interface.sv ====
`timescale 1ns/1ns
`include "qei_cfg.svh"
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin miscompares++; $display("BAD %s %h %h", n, e, s); end end

module tb_quadrature_encoder_interface;
	logic        i_mclk = 1'b0;
	logic        i_sys_rst = 1'b1;
	logic        i_phase_a_input;
	logic        i_phase_b_input;
	logic        i_index_input;
	logic [4:0]  i_addr = 5'h00;
	logic [31:0] i_wdata = 32'h0;
	logic        i_wr = 1'b0;
	logic        i_rd = 1'b0;
	logic [31:0] o_rdata;
	logic        o_direction;
	logic        o_event_pending;
	int          miscompares = 0;
	int          cmp_count = 0;
	logic [31:0] rv;

	quadrature_encoder_interface i_quadrature_encoder_interface
	(
		.i_mclk, .i_sys_rst, .i_phase_a_input, .i_phase_b_input, .i_index_input, .i_addr,
		.i_wdata, .i_wr, .i_rd, .o_rdata, .o_direction, .o_event_pending
	);
	encoder_model enc
	(
		.i_mclk,
		.o_phase_a (i_phase_a_input),
		.o_phase_b (i_phase_b_input),
		.o_index   (i_index_input)
	);

	initial
		forever #5 i_mclk = ~i_mclk;

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [4:0] a);
		@(posedge i_mclk);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1;
		rv = o_rdata;
	endtask : rd

	task automatic rc(input string n, input logic [4:0] a, input logic [31:0] e);
		rd(a);
		`CHK(n, e, rv)
	endtask : rc

	task automatic tmr();
		wr(`OFS_INT_CLEAR, 32'hf);
		rv = 32'h0;
		for (int n = 0; n < 200 && !rv[`EV_TIMER]; n++)
			rd(`OFS_INT_RAW);
		`CHK("expiry", 32'h8, rv & 32'h8)
		wr(`OFS_INT_CLEAR, 32'hf);
	endtask : tmr

	task automatic close_out();
		if (miscompares == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out

	initial
	begin
		repeat (20000) @(posedge i_mclk);
		miscompares++;
		close_out();
	end

	initial
	begin
		repeat (16) @(posedge i_mclk);
		i_sys_rst <= 1'b0;
		rc("ctl", `OFS_CONTROL, 32'h0);
		rc("stat", `OFS_STATUS, 32'h2);
		rc("void", 5'h1f, 32'h0);
		wr(`OFS_CONTROL, 32'h8);
		wr(`OFS_MAXPOS, 32'h7);
		rc("max", `OFS_MAXPOS, 32'h7);
		wr(`OFS_CONTROL, 32'h9);
		enc.quad(1'b1, 1);
		rc("fwd", `OFS_POSITION, 32'h4);
		`CHK("dir up", 1'b1, o_direction)
		enc.quad(1'b1, 1);
		rc("wrap", `OFS_POSITION, 32'h0);
		enc.quad(1'b0, 1);
		rc("back", `OFS_POSITION, 32'h4);
		`CHK("dir down", 1'b0, o_direction)
		enc.blip(1'b0, 1'b0, 1'b1);
		rc("index", `OFS_POSITION, 32'h0);
		wr(`OFS_CONTROL, 32'h1);
		enc.quad(1'b1, 1);
		rc("a only", `OFS_POSITION, 32'h2);
		wr(`OFS_CONTROL, 32'h11);
		enc.blip(1'b0, 1'b0, 1'b1);
		rc("no index", `OFS_POSITION, 32'h2);
		wr(`OFS_CONTROL, 32'h3);
		enc.quad(1'b1, 1);
		rc("swap", `OFS_POSITION, 32'h0);
		wr(`OFS_CONTROL, 32'h5);
		enc.steps(1'b0, 3);
		enc.steps(1'b1, 1);
		rc("steps", `OFS_POSITION, 32'h2);
		wr(`OFS_CONTROL, 32'h8);
		wr(`OFS_INT_CLEAR, 32'hf);
		enc.quad(1'b1, 1);
		enc.blip(1'b0, 1'b0, 1'b1);
		rc("off pos", `OFS_POSITION, 32'h2);
		rc("off ev", `OFS_INT_RAW, 32'h0);
		wr(`OFS_INT_MASK, 32'hf);
		rc("mask", `OFS_INT_MASK, 32'hf);
		wr(`OFS_CONTROL, 32'h9);
		enc.blip(1'b1, 1'b1, 1'b0);
		rc("clash", `OFS_POSITION, 32'h2);
		rc("masked", `OFS_INT_CLEAR, 32'h1);
		`CHK("pend", 1'b1, o_event_pending)
		wr(`OFS_INT_MASK, 32'h0);
		@(negedge i_mclk);
		`CHK("unpend", 1'b0, o_event_pending)
		wr(`OFS_INT_CLEAR, 32'hf);
		enc.blip(1'b1, 1'b0, 1'b0);
		rc("flip", `OFS_INT_RAW, 32'h2);
		for (int k = 0; k < 2; k++)
		begin
			wr(`OFS_RELOAD, 32'h96);
			wr(`OFS_CONTROL, k ? 32'ha9 : 32'h29);
			tmr();
			enc.quad(1'b1, 2);
			tmr();
			rc("speed", `OFS_SPEED, k ? 32'h2 : 32'h8);
			rc("acc", `OFS_VEL_ACC, 32'h0);
		end
		wr(`OFS_CONTROL, 32'h20);
		wr(`OFS_INT_CLEAR, 32'hf);
		repeat (400) @(posedge i_mclk);
		rc("vel alone", `OFS_INT_RAW, 32'h0);
		close_out();
	end
endmodule : tb_quadrature_encoder_interface
